// ===== verilog/dmc_core.sv
// Purpose: Device-side command, power and data-mask logic of a DDR2 rank.
// Assumes: clk_sys oversamples the differential link clock; all pins are synchronised.
// Notes:   Small backing store stands in for the array; burst length four.
`timescale 1ns/10ps
module dmc_core (
  input  wire logic                       clk_sys,
  input  wire logic                       nrst,
  input  wire logic                       ck,
  input  wire logic                       ck_n,
  input  wire logic                       cke,
  input  wire logic                       cs_n,
  input  wire logic                       ras_n,
  input  wire logic                       cas_n,
  input  wire logic                       we_n,
  input  wire logic                       odt,
  input  wire logic [dmc_pkg::BA_W-1:0]   ba,
  input  wire logic [dmc_pkg::ADDR_W-1:0] addr,
  input  wire logic [dmc_pkg::DM_W-1:0]   dm,
  input  wire logic                       dqs_in,
  input  wire logic [dmc_pkg::DQ_W-1:0]   dq_in,
  input  wire logic [1:0]                 org,
  output logic      [dmc_pkg::DQ_W-1:0]   dq_out,
  output logic                            dq_oe,
  output logic                            dqs_out,
  output logic                            dqs_n_out,
  output logic                            dqs_oe,
  output logic                            dqs_n_oe,
  output logic                            rdqs_oe,
  output logic                            term_en,
  output logic                            term_rdqs_en,
  output logic                            int_clk_en,
  output logic      [1:0]                 pwr_state
);
  import dmc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Pin synchronisation and crossing detection
  logic [SYNC_W-1:0] pins_s;
  logic              ck_s, ckn_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, odt_s, dqs_s;
  logic [BA_W-1:0]   ba_s;
  logic [ADDR_W-1:0] addr_s;
  logic [DM_W-1:0]   dm_s;
  logic [DQ_W-1:0]   dq_s;
  logic [1:0]        org_s;

  dmc_sync #(.W(SYNC_W)) u_sync (
    .clk_sys (clk_sys),
    .nrst    (nrst),
    .din     ({ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, odt, ba, addr, dm, dqs_in,
                dq_in, org}),
    .dout    (pins_s)
  );

  assign {ck_s, ckn_s, cke_s, cs_n_s, ras_n_s, cas_n_s, we_n_s, odt_s, ba_s, addr_s,
          dm_s, dqs_s, dq_s, org_s} = pins_s;

  logic hi_r, lo_r, dqs_prev_r;
  logic ck_hi, ck_lo, x_rise, x_fall, x_any, dqs_edge;
  assign ck_hi    = ck_s & ~ckn_s;
  assign ck_lo    = ~ck_s & ckn_s;
  assign x_rise   = ck_hi & ~hi_r;
  assign x_fall   = ck_lo & ~lo_r;
  assign x_any    = x_rise | x_fall;
  assign dqs_edge = dqs_s ^ dqs_prev_r;

  ////////////////////////////////////////////////////////////////////////////
  // State
  dmc_pwr_t              ps_r, ps_nxt;
  logic [ADDR_W-1:0]     mr_r, mr_nxt, emr1_r, emr1_nxt;
  logic [NBANK-1:0]      open_r, open_nxt;
  logic [ADDR_W-1:0]     row_r [NBANK], row_nxt [NBANK];
  logic [2:0]            rd_cnt_r, rd_cnt_nxt, wr_cnt_r, wr_cnt_nxt;
  logic [1:0]            col_r, col_nxt;
  logic [BA_W-1:0]       bnk_r, bnk_nxt;
  logic                  ap_r, ap_nxt;
  logic [DQ_W-1:0]       dq_out_r, dq_out_nxt;
  logic                  dq_oe_r, dq_oe_nxt, dqs_r, dqs_nxt;
  logic                  term_r, term_nxt, trdqs_r, trdqs_nxt;
  logic                  odt_lat_r, odt_lat_nxt;

  logic [DQ_W-1:0]       mem [16];
  logic                  mem_we;
  logic [3:0]            mem_idx;
  logic [DQ_W-1:0]       mem_wd;

  logic                  cmd_ok, rtt_on, rdqs_on, dqsn_on;
  dmc_cmd_t              cmd;
  logic [ADDR_W-1:0]     row_mask;
  logic [DM_W-1:0]       lane_mask;

  assign cmd     = dmc_cmd_t'({ras_n_s, cas_n_s, we_n_s});
  assign rtt_on  = emr1_r[EMR_RTT0_BIT] | emr1_r[EMR_RTT1_BIT];
  assign rdqs_on = emr1_r[EMR_RDQS_BIT] & (org_s == ORG_X8);
  assign dqsn_on = ~emr1_r[EMR_DQSN_BIT];
  assign row_mask = (org_s == ORG_X16) ? {1'b0, {(ADDR_W-1){1'b1}}}
                                       : {ADDR_W{1'b1}};
  // Commands count only on a rise crossing with CKE held and chip select low
  assign cmd_ok  = x_rise & ~cs_n_s & cke_s & (ps_r == PS_NORMAL);

  always_comb begin
    if (org_s == ORG_X16) begin
      lane_mask = dm_s;
    end else begin
      lane_mask = {DM_W{dm_s[0]}};
    end
    if (rdqs_on) begin
      lane_mask = '0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Next-state logic
  always_comb begin
    ps_nxt      = ps_r;
    mr_nxt      = mr_r;
    emr1_nxt    = emr1_r;
    open_nxt    = open_r;
    row_nxt     = row_r;
    rd_cnt_nxt  = rd_cnt_r;
    wr_cnt_nxt  = wr_cnt_r;
    col_nxt     = col_r;
    bnk_nxt     = bnk_r;
    ap_nxt      = ap_r;
    dq_out_nxt  = dq_out_r;
    dq_oe_nxt   = dq_oe_r;
    dqs_nxt     = dqs_r;
    odt_lat_nxt = odt_lat_r;
    mem_we      = 1'b0;
    mem_idx     = {bnk_r, col_r};
    mem_wd      = mem[mem_idx];

    // Power state, CKE looked at on the rise crossing except for refresh exit
    case (ps_r)
      PS_NORMAL: begin
        if (x_rise && !cke_s) begin
          if (!cs_n_s && cmd == CMD_REF) begin
            ps_nxt = PS_SREF;
          end else if (open_r != '0) begin
            ps_nxt = PS_PDN_ACT;
          end else begin
            ps_nxt = PS_PDN_PRE;
          end
        end
      end
      PS_PDN_PRE, PS_PDN_ACT: begin
        if (x_rise && cke_s) begin
          ps_nxt = PS_NORMAL;
        end
      end
      PS_SREF: begin
        if (cke_s) begin
          ps_nxt = PS_NORMAL;
        end
      end
      default: ps_nxt = PS_NORMAL;
    endcase

    // ODT is registered on the rise crossing; self-refresh drops its buffer
    if (ps_r == PS_SREF) begin
      odt_lat_nxt = 1'b0;
    end else if (x_rise) begin
      odt_lat_nxt = odt_s;
    end

    // Command decode
    if (cmd_ok) begin
      case (cmd)
        CMD_MRS: begin
          if (ba_s == BA_MR) begin
            mr_nxt = addr_s;
          end else if (ba_s == BA_EMR1) begin
            emr1_nxt = addr_s;
          end
        end
        CMD_ACT: begin
          open_nxt[ba_s] = 1'b1;
          row_nxt[ba_s]  = addr_s & row_mask;
        end
        CMD_PRE: begin
          if (addr_s[AP_BIT]) begin
            open_nxt = '0;
          end else begin
            open_nxt[ba_s] = 1'b0;
          end
        end
        CMD_RD: begin
          rd_cnt_nxt = BURST_BEATS;
          col_nxt    = addr_s[1:0];
          bnk_nxt    = ba_s;
          ap_nxt     = addr_s[AP_BIT];
        end
        CMD_WR: begin
          wr_cnt_nxt = BURST_BEATS;
          col_nxt    = addr_s[1:0];
          bnk_nxt    = ba_s;
          ap_nxt     = addr_s[AP_BIT];
        end
        default: begin
        end
      endcase
    end

    // Read burst: one beat per crossing, strobe toggles with the data
    if (rd_cnt_r != 3'h0 && x_any && !x_rise) begin
      dq_out_nxt = mem[mem_idx];
      dq_oe_nxt  = 1'b1;
      dqs_nxt    = ~dqs_r;
      col_nxt    = col_r + 2'h1;
      rd_cnt_nxt = rd_cnt_r - 3'h1;
    end else if (rd_cnt_r != 3'h0 && x_rise && dq_oe_r) begin
      dq_out_nxt = mem[mem_idx];
      dqs_nxt    = ~dqs_r;
      col_nxt    = col_r + 2'h1;
      rd_cnt_nxt = rd_cnt_r - 3'h1;
    end else if (rd_cnt_r == 3'h0 && dq_oe_r && x_any) begin
      dq_oe_nxt = 1'b0;
      dqs_nxt   = 1'b0;
      if (ap_r) begin
        open_nxt[bnk_r] = 1'b0;
      end
    end

    // Write burst: beats on both strobe edges, masked lanes keep old data
    if (wr_cnt_r != 3'h0 && dqs_edge) begin
      mem_we = 1'b1;
      mem_wd[7:0]  = lane_mask[0] ? mem[mem_idx][7:0]  : dq_s[7:0];
      mem_wd[15:8] = lane_mask[1] ? mem[mem_idx][15:8] : dq_s[15:8];
      col_nxt      = col_r + 2'h1;
      wr_cnt_nxt   = wr_cnt_r - 3'h1;
      if (wr_cnt_r == 3'h1 && ap_r) begin
        open_nxt[bnk_r] = 1'b0;
      end
    end
  end

  assign term_nxt  = odt_lat_r & rtt_on & (ps_r != PS_SREF);
  assign trdqs_nxt = term_nxt & rdqs_on;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      hi_r       <= 1'b0;
      lo_r       <= 1'b0;
      dqs_prev_r <= 1'b0;
      ps_r       <= PS_NORMAL;
      mr_r       <= MR_RST;
      emr1_r     <= EMR1_RST;
      open_r     <= '0;
      for (int i = 0; i < NBANK; i++) begin
        row_r[i] <= '0;
      end
      rd_cnt_r   <= 3'h0;
      wr_cnt_r   <= 3'h0;
      col_r      <= 2'h0;
      bnk_r      <= '0;
      ap_r       <= 1'b0;
      dq_out_r   <= '0;
      dq_oe_r    <= 1'b0;
      dqs_r      <= 1'b0;
      odt_lat_r  <= 1'b0;
      term_r     <= 1'b0;
      trdqs_r    <= 1'b0;
    end else begin
      hi_r       <= ck_hi;
      lo_r       <= ck_lo;
      dqs_prev_r <= dqs_s;
      ps_r       <= ps_nxt;
      mr_r       <= mr_nxt;
      emr1_r     <= emr1_nxt;
      open_r     <= open_nxt;
      row_r      <= row_nxt;
      rd_cnt_r   <= rd_cnt_nxt;
      wr_cnt_r   <= wr_cnt_nxt;
      col_r      <= col_nxt;
      bnk_r      <= bnk_nxt;
      ap_r       <= ap_nxt;
      dq_out_r   <= dq_out_nxt;
      dq_oe_r    <= dq_oe_nxt;
      dqs_r      <= dqs_nxt;
      odt_lat_r  <= odt_lat_nxt;
      term_r     <= term_nxt;
      trdqs_r    <= trdqs_nxt;
    end
  end

  // Array contents carry no reset, as in the real cell array
  always_ff @(posedge clk_sys) begin
    if (mem_we) begin
      mem[mem_idx] <= mem_wd;
    end
  end

  // Strobe enables are taken from the same flip-flops as the data
  assign dq_out       = dq_out_r;
  assign dq_oe        = dq_oe_r;
  assign dqs_out      = dqs_r;
  assign dqs_n_out    = ~dqs_r;
  assign dqs_oe       = dq_oe_r;
  assign dqs_n_oe     = dq_oe_r & ~emr1_r[EMR_DQSN_BIT];
  // Read strobe pair exists on x8 only, so other straps never drive it
  assign rdqs_oe      = dq_oe_r & rdqs_on;
  assign term_en      = term_r;
  assign term_rdqs_en = trdqs_r;
  assign int_clk_en   = (ps_r == PS_NORMAL);
  assign pwr_state    = ps_r;

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!nrst);

  property p_cs_mask;
    (x_rise && cs_n_s && ps_r == PS_NORMAL && rd_cnt_r == 3'h0) |=> open_r == $past(open_r);
  endproperty
  a_cs_mask: assert property (p_cs_mask) else $error("command taken while deselected");

  property p_pre_all;
    (cmd_ok && cmd == CMD_PRE && addr_s[AP_BIT]) |=> open_r == '0;
  endproperty
  a_pre_all: assert property (p_pre_all) else $error("precharge all left a bank open");

  property p_act_open;
    (cmd_ok && cmd == CMD_ACT) |=> open_r[$past(ba_s)];
  endproperty
  a_act_open: assert property (p_act_open) else $error("activate did not open bank");

  property p_x16_row;
    (cmd_ok && cmd == CMD_ACT && org_s == ORG_X16) |=> !row_r[$past(ba_s)][ROW_TOP_BIT];
  endproperty
  a_x16_row: assert property (p_x16_row) else $error("top row bit kept on x16");

  property p_odt_off;
    !rtt_on |=> !term_en;
  endproperty
  a_odt_off: assert property (p_odt_off) else $error("termination on while disabled");

  property p_sref_exit;
    (ps_r == PS_SREF && cke_s) |=> ps_r == PS_NORMAL;
  endproperty
  a_sref_exit: assert property (p_sref_exit) else $error("self-refresh exit missed");

  property p_pdn_entry;
    (ps_r == PS_NORMAL && x_rise && !cke_s && open_r != '0 && cs_n_s) |=> ps_r == PS_PDN_ACT;
  endproperty
  a_pdn_entry: assert property (p_pdn_entry) else $error("active power-down not entered");

  property p_pdn_hold;
    (ps_r == PS_PDN_PRE && !x_rise) |=> ps_r == PS_PDN_PRE;
  endproperty
  a_pdn_hold: assert property (p_pdn_hold) else $error("power-down left off a crossing");

  property p_dqsn;
    emr1_r[EMR_DQSN_BIT] |-> !dqs_n_oe;
  endproperty
  a_dqsn: assert property (p_dqsn) else $error("complementary strobe driven while off");

  property p_sref_odt;
    (ps_r == PS_SREF) [*2] |-> !term_en;
  endproperty
  a_sref_odt: assert property (p_sref_odt) else $error("termination during self-refresh");

endmodule : dmc_core

// ===== verilog/dmc_pkg.sv
// Purpose: Shared constants for the DDR2 module command interface.
// Assumes: Command pins are sampled by clk_sys after a two-stage synchroniser.
// Notes:   Burst length is fixed at four beats.
package dmc_pkg;

  // Organisation codes on the org strap
  localparam logic [1:0] ORG_X4  = 2'h0;
  localparam logic [1:0] ORG_X8  = 2'h1;
  localparam logic [1:0] ORG_X16 = 2'h2;

  // Widths
  localparam int ADDR_W  = 14;
  localparam int BA_W    = 2;
  localparam int DQ_W    = 16;
  localparam int DM_W    = 2;
  localparam int NBANK   = 4;
  // Every synchronised pin, ck through org
  localparam int SYNC_W  = 45;

  // Address bit positions
  localparam int AP_BIT        = 10;
  localparam int ROW_TOP_BIT   = 13;
  localparam int EMR_RTT0_BIT  = 2;
  localparam int EMR_RTT1_BIT  = 6;
  localparam int EMR_DQSN_BIT  = 10;
  localparam int EMR_RDQS_BIT  = 11;

  // Mode register selects on the bank address
  localparam logic [1:0] BA_MR   = 2'h0;
  localparam logic [1:0] BA_EMR1 = 2'h1;

  // Reset values
  localparam logic [13:0] MR_RST   = 14'h0000;
  localparam logic [13:0] EMR1_RST = 14'h0000;

  // Burst
  localparam logic [2:0] BURST_BEATS = 3'h4;

  // Command code {ras_n, cas_n, we_n} with chip select low
  typedef enum logic [2:0] {
    CMD_MRS = 3'b000,
    CMD_REF = 3'b001,
    CMD_PRE = 3'b010,
    CMD_ACT = 3'b011,
    CMD_WR  = 3'b100,
    CMD_RD  = 3'b101,
    CMD_BST = 3'b110,
    CMD_NOP = 3'b111
  } dmc_cmd_t;

  typedef enum logic [1:0] {
    PS_NORMAL  = 2'b00,
    PS_PDN_PRE = 2'b01,
    PS_PDN_ACT = 2'b10,
    PS_SREF    = 2'b11
  } dmc_pwr_t;

endpackage : dmc_pkg

// ===== verilog/dmc_sync.sv
// Purpose: Two-stage synchroniser for a bundle of pin inputs.
// Assumes: Each bit is an independent level from outside clk_sys.
// Notes:   Only the second stage leaves this module.
`timescale 1ns/10ps
module dmc_sync #(
  parameter int W = 8
) (
  input  wire logic         clk_sys,
  input  wire logic         nrst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);
  logic [W-1:0] meta_r;
  logic [W-1:0] sync_r;

  always_ff @(posedge clk_sys) begin
    if (!nrst) begin
      meta_r <= '0;
      sync_r <= '0;
    end else begin
      meta_r <= din;
      sync_r <= meta_r;
    end
  end

  assign dout = sync_r;
endmodule : dmc_sync

// ===== test/dmc_ctl_model.sv
// Purpose: Behavioural memory controller driving the rank's command and write pins.
// Assumes: Link clock runs free at 160 ns, phase offset from clk_sys.
// Notes:   Released address and data lines are inverted so a stale value never looks valid; command lines return high.
`timescale 1ns/10ps
module dmc_ctl_model (
  input  wire logic                       clk_sys,
  output logic                            ck,
  output logic                            ck_n,
  output logic                            cke,
  output logic                            cs_n,
  output logic                            ras_n,
  output logic                            cas_n,
  output logic                            we_n,
  output logic                            odt,
  output logic      [dmc_pkg::BA_W-1:0]   ba,
  output logic      [dmc_pkg::ADDR_W-1:0] addr,
  output logic      [dmc_pkg::DM_W-1:0]   dm,
  output logic                            dqs_in,
  output logic      [dmc_pkg::DQ_W-1:0]   dq_in
);
  import dmc_pkg::*;
  initial begin
    {cke, cs_n, ras_n, cas_n, we_n} = 5'h1F;
    {odt, ba, addr, dm, dqs_in, dq_in} = '0;
    ck = 1'b0;
    #3.3;
    forever #80 ck = ~ck;
  end
  assign ck_n = ~ck;
  ////////////////////////////////////////////////////////////////////////////////
  // Launched after a fall so the lines are stable a half period each side of the rise
  task automatic cmd(input logic k, input logic s, input dmc_cmd_t c,
                     input logic [1:0] b, input logic [13:0] a, input logic o);
    @(negedge ck);
    @(posedge clk_sys);
    {cke, cs_n, ras_n, cas_n, we_n} <= {k, s, c};
    ba <= b;
    addr <= a;
    odt <= o;
    @(negedge ck);
    @(posedge clk_sys);
    {cs_n, ras_n, cas_n, we_n} <= 4'hF;
    ba <= ~b;
    addr <= ~a;
  endtask : cmd
  task automatic wburst(input logic [3:0][15:0] w, input logic [3:0][1:0] m);
    cke <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      @(posedge clk_sys);
      dq_in <= w[i];
      dm <= m[i];
      repeat (4) @(posedge clk_sys);
      dqs_in <= ~dqs_in;
      repeat (4) @(posedge clk_sys);
    end
    dq_in <= ~w[3];
    dm <= ~m[3];
  endtask : wburst
  task automatic wake();
    @(posedge clk_sys);
    cke <= 1'b1;
  endtask : wake
endmodule : dmc_ctl_model

// ===== test/ddr2_module_command_interface_tb.sv
// Purpose: Self-checking bench for the rank command, power and data-mask logic.
// Assumes: Array contents survive reset, so each org starts with unmasked writes.
// Notes:   Every org strap is run after its own reset.
`timescale 1ns/10ps
module ddr2_module_command_interface_tb;
  import dmc_pkg::*;
  logic        clk_sys, nrst, ck, ck_n, cke, cs_n, ras_n, cas_n, we_n, odt, dqs_in;
  logic        dq_oe, dqs_out, dqs_n_out, dqs_oe, dqs_n_oe, rdqs_oe, term_en;
  logic        term_rdqs_en, int_clk_en, prev_dqs;
  logic [1:0]  org, ba, dm, pwr_state;
  logic [13:0] addr, emr;
  logic [15:0] dq_in, dq_out;
  logic [15:0] mem [16];
  logic [15:0] rq [$];
  int          error_cnt, checked;
  initial clk_sys = 1'b0;
  always #5 clk_sys = ~clk_sys;
  dmc_ctl_model dmc_ctl_model_inst (
    .clk_sys, .ck, .ck_n, .cke, .cs_n, .ras_n, .cas_n, .we_n, .odt, .ba, .addr, .dm,
    .dqs_in, .dq_in
  );
  dmc_core dmc_core_inst (
    .clk_sys, .nrst, .ck, .ck_n, .cke, .cs_n, .ras_n, .cas_n, .we_n, .odt, .ba, .addr,
    .dm, .dqs_in, .dq_in, .org, .dq_out, .dq_oe, .dqs_out, .dqs_n_out, .dqs_oe,
    .dqs_n_oe, .rdqs_oe, .term_en, .term_rdqs_en, .int_clk_en, .pwr_state
  );
  ////////////////////////////////////////////////////////////////////////////////
  task automatic chk(input logic [31:0] s, input logic [31:0] e);
    checked++;
    if (s !== e) begin
      error_cnt++;
      $display("Error at %0t ns: seen %0h expected %0h", $time, s, e);
    end
  endtask : chk
  task automatic test_done();
    $display("Comparisons %0d, mismatches %0d", checked, error_cnt);
    if (error_cnt == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask : test_done
  // A read beat is any strobe toggle while the data drivers are on
  always @(posedge clk_sys) begin
    prev_dqs <= dqs_out;
    if (dq_oe === 1'b1 && dqs_out !== prev_dqs) begin
      rq.push_back(dq_out);
      chk(dqs_n_oe, !emr[EMR_DQSN_BIT]);
      chk(rdqs_oe, org == ORG_X8 && emr[EMR_RDQS_BIT]);
      chk({dqs_oe, dqs_n_out}, {1'b1, ~dqs_out});
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  function automatic logic [15:0] merge(logic [15:0] o, logic [15:0] n, logic [1:0] m);
    logic [1:0] k;
    k = (org == ORG_X16) ? m : {2{m[0]}};
    if (org == ORG_X8 && emr[EMR_RDQS_BIT]) k = 2'h0;
    return {k[1] ? o[15:8] : n[15:8], k[0] ? o[7:0] : n[7:0]};
  endfunction : merge
  task automatic cmd(input logic k, input logic s, input dmc_cmd_t c,
                     input logic [1:0] b, input logic [13:0] a, input logic o);
    dmc_ctl_model_inst.cmd(k, s, c, b, a, o);
  endtask : cmd
  task automatic mrs(input logic [1:0] b, input logic [13:0] a);
    cmd(1'b1, 1'b0, CMD_MRS, b, a, 1'b1);
    if (b == BA_EMR1) emr = a;
  endtask : mrs
  task automatic ot(input logic o, input logic e);
    cmd(1'b1, 1'b1, CMD_NOP, 2'h0, 14'h0000, o);
    chk(term_en, e);
  endtask : ot
  task automatic do_reset(input logic [1:0] o);
    @(posedge clk_sys);
    nrst <= 1'b0;
    org <= o;
    repeat (16) @(posedge clk_sys);
    chk({dq_oe, dqs_oe, dqs_n_out, int_clk_en, pwr_state, term_en}, 7'b0011000);
    nrst <= 1'b1;
    emr = '0;
    repeat (3) @(posedge clk_sys);
  endtask : do_reset
  task automatic xfer(input logic [1:0] b, input logic rm);
    logic [3:0][15:0] w;
    logic [3:0][1:0]  m;
    logic [1:0]       col;
    logic [13:0]      a;
    w = {$urandom, $urandom};
    m = rm ? 8'($urandom) : 8'h00;
    col = 2'($urandom);
    a = {3'($urandom), 1'b0, 8'($urandom), col};
    cmd(1'b1, 1'b0, CMD_ACT, b, 14'($urandom), 1'b0);
    cmd(1'b1, 1'b0, CMD_WR, b, a, 1'b0);
    dmc_ctl_model_inst.wburst(w, m);
    for (int i = 0; i < 4; i++) mem[{b, col + 2'(i)}] = merge(mem[{b, col + 2'(i)}], w[i], m[i]);
    rq.delete();
    a[AP_BIT] = b[0];
    cmd(1'b1, 1'b0, CMD_RD, b, a, 1'b0);
    for (int t = 0; t < 200 && rq.size() < 4; t++) @(posedge clk_sys);
    chk(rq.size(), 4);
    for (int i = 0; i < 4 && i < rq.size(); i++) chk(rq[i], mem[{b, col + 2'(i)}]);
  endtask : xfer
  task automatic pd(input dmc_cmd_t c, input dmc_pwr_t e);
    cmd(1'b0, c == CMD_NOP, c, 2'h0, 14'h0000, 1'b1);
    chk({pwr_state, int_clk_en, term_en}, {e, 1'b0, e != PS_SREF});
    if (e != PS_SREF) begin
      rq.delete();
      cmd(1'b0, 1'b0, CMD_RD, 2'h0, 14'h0000, 1'b1);
      repeat (40) @(posedge clk_sys);
      chk(rq.size(), 0);
      cmd(1'b1, 1'b1, CMD_NOP, 2'h0, 14'h0000, 1'b1);
      chk({pwr_state, int_clk_en}, {PS_NORMAL, 1'b1});
    end
  endtask : pd
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    #200_000;
    error_cnt++;
    test_done();
  end
  initial begin
    nrst = 1'b0;
    org = ORG_X4;
    emr = '0;
    void'($urandom(94749));
    for (int o = 0; o < 3; o++) begin
      do_reset(2'(o));
      mrs(BA_EMR1, 14'h0004);
      ot(1'b1, 1'b1);
      cmd(1'b1, 1'b1, CMD_MRS, BA_EMR1, 14'h0000, 1'b1);
      ot(1'b1, 1'b1);
      mrs(BA_MR, 14'h0000);
      ot(1'b1, 1'b1);
      mrs(BA_EMR1, 14'h0000);
      ot(1'b1, 1'b0);
      mrs(BA_EMR1, 14'h0840);
      ot(1'b1, 1'b1);
      chk(term_rdqs_en, org == ORG_X8);
      ot(1'b0, 1'b0);
      cmd(1'b1, 1'b0, CMD_REF, 2'h0, 14'h0000, 1'b0);
      cmd(1'b1, 1'b0, CMD_BST, 2'h0, 14'h0000, 1'b0);
      chk({pwr_state, dq_oe}, {PS_NORMAL, 1'b0});
      // Pass 0 fills every word unmasked; later passes mask at random
      for (int p = 0; p < 3; p++) begin
        mrs(BA_EMR1, (p == 2) ? 14'h0C00 : 14'h0000);
        cmd(1'b1, 1'b0, CMD_PRE, 2'h0, 14'h0400, 1'b0);
        for (int b = 0; b < NBANK; b++) xfer(2'(b), p != 0);
      end
      mrs(BA_EMR1, 14'h0004);
      cmd(1'b1, 1'b0, CMD_PRE, 2'h0, 14'h0000, 1'b1);
      cmd(1'b1, 1'b0, CMD_PRE, 2'h2, 14'h0000, 1'b1);
      pd(CMD_NOP, PS_PDN_PRE);
      cmd(1'b1, 1'b0, CMD_ACT, 2'h1, 14'h0000, 1'b1);
      cmd(1'b1, 1'b0, CMD_ACT, 2'h2, 14'h0000, 1'b1);
      cmd(1'b1, 1'b0, CMD_PRE, 2'h1, 14'h0000, 1'b1);
      pd(CMD_NOP, PS_PDN_ACT);
      cmd(1'b1, 1'b0, CMD_PRE, 2'h0, 14'h0400, 1'b1);
      pd(CMD_NOP, PS_PDN_PRE);
      pd(CMD_REF, PS_SREF);
      dmc_ctl_model_inst.wake();
      repeat (5) @(posedge clk_sys);
      chk({pwr_state, int_clk_en}, {PS_NORMAL, 1'b1});
    end
    test_done();
  end
endmodule : ddr2_module_command_interface_tb
